// file: rtl/tap_regs.svh
`ifndef TAP_REGS_SVH
`define TAP_REGS_SVH

// ----------------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------------
`define IR_WIDTH          3
// value captured into the two low bits on capture-ir
`define IR_CAPTURE_LOW    2'h1
`define IR_CAPTURE_HIGH   1'h0

// opcodes, binary msb left
`define OP_EXTEST         3'h0
`define OP_IDCODE         3'h1
`define OP_SAMPLE_Z       3'h2
`define OP_RESERVED_3     3'h3
`define OP_SAMPLE_PRELOAD 3'h4
`define OP_RESERVED_5     3'h5
`define OP_RESERVED_6     3'h6
`define OP_BYPASS         3'h7

// ----------------------------------------------------------------------
// data registers
// ----------------------------------------------------------------------
`define ID_WIDTH          32
// identification value is arbitrary; bit 0 set as a scan marker
`define IDENTIFICATION_ROM_DEFAULT    32'h0a5c_3e01
`define BSR_WIDTH         51
`define SYNC_STAGES       2

`endif

// file: rtl/tap_pkg.sv
package tap_pkg;

   // pins from the external test controller
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } jtag_in_s;

   // tap controller states, gray steps along the usual path
   typedef enum logic [3:0] {
      ST_RESET      = 4'h0,
      ST_IDLE       = 4'h1,
      ST_SEL_DR     = 4'h3,
      ST_CAP_DR     = 4'h2,
      ST_SHIFT_DR   = 4'h6,
      ST_EXIT1_DR   = 4'h7,
      ST_PAUSE_DR   = 4'h5,
      ST_EXIT2_DR   = 4'h4,
      ST_UPD_DR     = 4'hc,
      ST_SEL_IR     = 4'hd,
      ST_CAP_IR     = 4'hf,
      ST_SHIFT_IR   = 4'he,
      ST_EXIT1_IR   = 4'ha,
      ST_PAUSE_IR   = 4'hb,
      ST_EXIT2_IR   = 4'h9,
      ST_UPD_IR     = 4'h8
   } tap_state_e;

   // which data register sits between tdi and tdo
   typedef enum logic [1:0] {
      DR_BYPASS = 2'h0,
      DR_ID     = 2'h1,
      DR_BSR    = 2'h2
   } dr_sel_e;

endpackage

// file: rtl/sync2.sv
`timescale 1ns/100ps
module sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,    // sampling clock
   input  wire logic             rst,    // synchronous reset
   input  wire logic [WIDTH-1:0] d,      // asynchronous input
   output logic      [WIDTH-1:0] q       // synchronised output
);
   logic [WIDTH-1:0] meta_reg;

   // first stage feeds only the second
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule

// file: rtl/sram_tap_instruction_decode.sv
// How it works
// - idcode: capture rom, shift id register
// - idcode after reset and test-logic-reset
// - opcode 001 is idcode, ram unaffected
// - sample-z floats outputs, shifts boundary register
// - opcode 010 is sample-z, captures pads
// - opcode 000 extest: capture, shift, float
// - opcode 100 sample/preload: capture, shift only
// - opcode 111 bypass: one-bit register, ram unaffected
// - opcodes binary, msb leftmost
// - capture-ir loads 01, ir shifts in shift-ir
// - new instruction takes effect at update-ir
// - update-dr changes nothing, like pause-dr
`timescale 1ns/100ps
`include "tap_regs.svh"
module sram_tap_instruction_decode #(
   parameter logic [`ID_WIDTH-1:0] IDENTIFICATION_ROM = `IDENTIFICATION_ROM_DEFAULT
) (
   input  wire logic                   core_clk,      // 40 mhz clock
   input  wire logic                   rst,           // sync reset
   input  wire tap_pkg::jtag_in_s      jtag_in,       // tck/tms/tdi
   input  wire logic [`BSR_WIDTH-1:0]  pad_ring,      // ram pad levels
   output logic                        tdo,           // test data out
   output logic                        tdo_oe,        // tdo driven
   output logic                        ram_out_float, // ram outputs hi-z
   output logic [`IR_WIDTH-1:0]        cur_instr      // active opcode
);
   import tap_pkg::*;

   // ----------------------------------------------------------------
   // pin synchronisers and tck edges
   // ----------------------------------------------------------------
   jtag_in_s               jtag_s;
   logic [`BSR_WIDTH-1:0]  pad_s;
   logic                   tck_d_reg;
   logic                   tck_rise;
   logic                   tck_fall;

   sync2 #(.WIDTH(3)) u_sync_jtag (
      .clk (core_clk),
      .rst (rst),
      .d   (jtag_in),
      .q   (jtag_s)
   );

   // pads belong to the ram clock; capture is only repeatable if the
   // ram holds them steady around the capture edge
   sync2 #(.WIDTH(`BSR_WIDTH)) u_sync_pads (
      .clk (core_clk),
      .rst (rst),
      .d   (pad_ring),
      .q   (pad_s)
   );

   always_ff @(posedge core_clk) begin
      if (rst) begin
         tck_d_reg <= 1'b0;
      end else begin
         tck_d_reg <= jtag_s.tck;
      end
   end

   assign tck_rise = jtag_s.tck & ~tck_d_reg;
   assign tck_fall = ~jtag_s.tck & tck_d_reg;

   // ----------------------------------------------------------------
   // tap state machine
   // ----------------------------------------------------------------
   tap_state_e state_reg;
   tap_state_e state_next;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_RESET:    state_next = jtag_s.tms ? ST_RESET    : ST_IDLE;
         ST_IDLE:     state_next = jtag_s.tms ? ST_SEL_DR   : ST_IDLE;
         ST_SEL_DR:   state_next = jtag_s.tms ? ST_SEL_IR   : ST_CAP_DR;
         ST_CAP_DR:   state_next = jtag_s.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_SHIFT_DR: state_next = jtag_s.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_EXIT1_DR: state_next = jtag_s.tms ? ST_UPD_DR   : ST_PAUSE_DR;
         ST_PAUSE_DR: state_next = jtag_s.tms ? ST_EXIT2_DR : ST_PAUSE_DR;
         ST_EXIT2_DR: state_next = jtag_s.tms ? ST_UPD_DR   : ST_SHIFT_DR;
         ST_UPD_DR:   state_next = jtag_s.tms ? ST_SEL_DR   : ST_IDLE;
         ST_SEL_IR:   state_next = jtag_s.tms ? ST_RESET    : ST_CAP_IR;
         ST_CAP_IR:   state_next = jtag_s.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_SHIFT_IR: state_next = jtag_s.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_EXIT1_IR: state_next = jtag_s.tms ? ST_UPD_IR   : ST_PAUSE_IR;
         ST_PAUSE_IR: state_next = jtag_s.tms ? ST_EXIT2_IR : ST_PAUSE_IR;
         ST_EXIT2_IR: state_next = jtag_s.tms ? ST_UPD_IR   : ST_SHIFT_IR;
         ST_UPD_IR:   state_next = jtag_s.tms ? ST_SEL_DR   : ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_reg <= ST_RESET;
      end else if (tck_rise) begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // instruction register
   // ----------------------------------------------------------------
   logic [`IR_WIDTH-1:0] ir_shift_reg;

   // lsb leaves first at tdo, so the msb is the last bit shifted in
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ir_shift_reg <= `OP_IDCODE;
      end else if (tck_rise) begin
         if (state_reg == ST_CAP_IR) begin
            ir_shift_reg <= {`IR_CAPTURE_HIGH, `IR_CAPTURE_LOW};
         end else if (state_reg == ST_SHIFT_IR) begin
            ir_shift_reg <= {jtag_s.tdi,
                             ir_shift_reg[`IR_WIDTH-1:1]};
         end
      end
   end

   // the old opcode keeps running while a new one shifts in
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cur_instr <= `OP_IDCODE;
      end else if (tck_rise) begin
         if (state_next == ST_RESET) begin
            cur_instr <= `OP_IDCODE;
         end else if (state_next == ST_UPD_IR) begin
            cur_instr <= ir_shift_reg;
         end
      end
   end

   // ----------------------------------------------------------------
   // opcode decode
   // ----------------------------------------------------------------
   dr_sel_e dr_sel;
   logic    float_next;

   always_comb begin
      dr_sel     = DR_BYPASS;
      float_next = 1'b0;
      unique case (cur_instr)
         `OP_EXTEST: begin
            dr_sel     = DR_BSR;
            float_next = 1'b1;
         end
         `OP_IDCODE: begin
            dr_sel     = DR_ID;
         end
         `OP_SAMPLE_Z: begin
            dr_sel     = DR_BSR;
            float_next = 1'b1;
         end
         `OP_SAMPLE_PRELOAD: begin
            dr_sel     = DR_BSR;
         end
         `OP_BYPASS: begin
            dr_sel     = DR_BYPASS;
         end
         default: begin
            // reserved codes keep the chain one bit long
            dr_sel     = DR_BYPASS;
            float_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ram_out_float <= 1'b0;
      end else begin
         ram_out_float <= float_next;
      end
   end

   // ----------------------------------------------------------------
   // data registers
   // ----------------------------------------------------------------
   logic [`ID_WIDTH-1:0]  id_reg;
   logic [`BSR_WIDTH-1:0] bsr_reg;
   logic                  bypass_reg;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         id_reg <= '0;
      end else if (tck_rise && dr_sel == DR_ID) begin
         if (state_reg == ST_CAP_DR) begin
            id_reg <= IDENTIFICATION_ROM;
         end else if (state_reg == ST_SHIFT_DR) begin
            id_reg <= {jtag_s.tdi, id_reg[`ID_WIDTH-1:1]};
         end
      end
   end

   // update-dr has no branch here: no preload latch exists
   always_ff @(posedge core_clk) begin
      if (rst) begin
         bsr_reg <= '0;
      end else if (tck_rise && dr_sel == DR_BSR) begin
         if (state_reg == ST_CAP_DR) begin
            bsr_reg <= pad_s;
         end else if (state_reg == ST_SHIFT_DR) begin
            bsr_reg <= {jtag_s.tdi,
                        bsr_reg[`BSR_WIDTH-1:1]};
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         bypass_reg <= 1'b0;
      end else if (tck_rise && dr_sel == DR_BYPASS) begin
         if (state_reg == ST_CAP_DR) begin
            bypass_reg <= 1'b0;
         end else if (state_reg == ST_SHIFT_DR) begin
            bypass_reg <= jtag_s.tdi;
         end
      end
   end

   // ----------------------------------------------------------------
   // tdo, changed on the falling tck edge
   // ----------------------------------------------------------------
   logic dr_lsb;

   always_comb begin
      dr_lsb = bypass_reg;
      unique case (dr_sel)
         DR_ID:     dr_lsb = id_reg[0];
         DR_BSR:    dr_lsb = bsr_reg[0];
         DR_BYPASS: dr_lsb = bypass_reg;
         default:   dr_lsb = bypass_reg;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         tdo    <= 1'b0;
         tdo_oe <= 1'b0;
      end else if (tck_fall) begin
         if (state_reg == ST_SHIFT_IR) begin
            tdo    <= ir_shift_reg[0];
            tdo_oe <= 1'b1;
         end else if (state_reg == ST_SHIFT_DR) begin
            tdo    <= dr_lsb;
            tdo_oe <= 1'b1;
         end else begin
            tdo_oe <= 1'b0;
         end
      end
   end
endmodule

// file: verification/tap_decode_props.sv
`timescale 1ns/100ps
`include "tap_regs.svh"
module tap_decode_props (
   input wire logic                  core_clk,      // core clock
   input wire logic                  rst,           // sync reset
   input wire tap_pkg::jtag_in_s     jtag_in,       // test pins
   input wire logic [`BSR_WIDTH-1:0] pad_ring,      // pad levels
   input wire logic                  tdo,           // test data out
   input wire logic                  tdo_oe,        // tdo driven
   input wire logic                  ram_out_float, // outputs hi-z
   input wire logic [`IR_WIDTH-1:0]  cur_instr      // active opcode
);
   import tap_pkg::*;
   // --------
   // pin edges reach the core through a window of 2 to 5 clocks
   // --------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   chk_float_set: assert property (
      !$past(rst) && $past(cur_instr) inside {`OP_EXTEST, `OP_SAMPLE_Z}
      |-> ram_out_float) else $error("outputs not floated");
   chk_id_drive: assert property (
      $past(cur_instr) == `OP_IDCODE |-> !ram_out_float)
      else $error("idcode floated outputs");
   chk_sample_drive: assert property (
      $past(cur_instr) == `OP_SAMPLE_PRELOAD |-> !ram_out_float)
      else $error("sample floated outputs");
   chk_bypass_drive: assert property (
      $past(cur_instr) inside {`OP_BYPASS, `OP_RESERVED_3,
      `OP_RESERVED_5, `OP_RESERVED_6} |-> !ram_out_float)
      else $error("bypass floated outputs");
   chk_reset_id: assert property (
      $fell(rst) |-> cur_instr == `OP_IDCODE && !tdo_oe && !ram_out_float)
      else $error("reset state wrong");
   chk_instr_hold: assert property (
      tdo_oe && $past(tdo_oe) |-> $stable(cur_instr))
      else $error("instruction changed in shift");
   chk_tdo_fall: assert property (
      !$stable(tdo) |-> !$past(jtag_in.tck, 2) && $past(jtag_in.tck, 5))
      else $error("tdo moved without a tck fall");
   chk_oe_fall: assert property (
      $rose(tdo_oe) |-> !$past(jtag_in.tck, 2) && $past(jtag_in.tck, 5))
      else $error("tdo enable rose without a tck fall");
   chk_instr_rise: assert property (
      !$stable(cur_instr) |-> $past(jtag_in.tck, 2) && !$past(jtag_in.tck, 5))
      else $error("instruction moved without a tck rise");
   chk_float_steady: assert property (
      !$stable(ram_out_float) |-> $past(cur_instr) != $past(cur_instr, 2))
      else $error("outputs changed without a new instruction");
   cov_float: cover property ($rose(ram_out_float));
   cov_reserved: cover property (cur_instr == `OP_RESERVED_6);
   cov_shift: cover property ($rose(tdo_oe));
endmodule
bind sram_tap_instruction_decode tap_decode_props u_props (
   .core_clk(core_clk), .rst(rst), .jtag_in(jtag_in),
   .pad_ring(pad_ring), .tdo(tdo), .tdo_oe(tdo_oe),
   .ram_out_float(ram_out_float), .cur_instr(cur_instr));

// file: verification/jtag_ctrl.sv
`timescale 1ns/100ps
module jtag_ctrl (
   input  wire logic         core_clk, // timing reference
   input  wire logic         tdo,      // device test data
   input  wire logic         tdo_oe,   // device drives tdo
   output tap_pkg::jtag_in_s jtag_in   // tck, tms, tdi
);
   import tap_pkg::*;
   logic line;
   // tdo has a pull-up, so a released line reads high
   assign line = tdo_oe ? tdo : 1'b1;
   initial jtag_in = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0};
   // --------
   // one tck of 8 clocks; tms/tdi move at the fall, steady across the rise
   // --------
   task automatic step(input logic ms, input logic di, output logic o);
      @(posedge core_clk);
      #1 jtag_in = '{tck: 1'b0, tms: ms, tdi: di};
      repeat (4) @(posedge core_clk);
      #1 jtag_in.tck = 1'b1;
      repeat (2) @(posedge core_clk);
      o = line;
      @(posedge core_clk);
   endtask
   task automatic walk(input logic [7:0] ms, input int n);
      logic o;
      for (int i = 0; i < n; i++) step(ms[i], 1'b0, o);
   endtask
   // tck stands still between frames and tdi shows the opposite level
   task automatic park;
      @(posedge core_clk);
      #1 jtag_in = '{tck: 1'b0, tms: 1'b0, tdi: ~jtag_in.tdi};
   endtask
   // reserved codes go out only when the bench asks
   task automatic ir_load(input logic [2:0] op, output logic [2:0] cap);
      logic o;
      walk(8'h03, 4);
      for (int i = 0; i < 3; i++) begin
         step(i == 2, op[i], o);
         cap[i] = o;
      end
      walk(8'h01, 2);
      park();
   endtask
   task automatic dr_read(input logic [63:0] r, output logic [63:0] d);
      logic o;
      walk(8'h01, 3);
      for (int i = 0; i < 64; i++) begin
         step(i == 63, r[i], o);
         d[i] = o;
      end
      walk(8'h01, 2);
      park();
   endtask
endmodule

// file: verification/tb.sv
`timescale 1ns/100ps
`include "tap_regs.svh"
module tb;
   import tap_pkg::*;
   // arbitrary identification value
   localparam logic [`ID_WIDTH-1:0] ID_VAL = 32'h5a3c_0f81;
   logic                  core_clk = 1'b0;
   logic                  rst = 1'b1;
   jtag_in_s              jtag_in;
   logic [`BSR_WIDTH-1:0] pad_ring = '0;
   logic                  tdo;
   logic                  tdo_oe;
   logic                  ram_out_float;
   logic [2:0]            cur_instr;
   logic [2:0]            last = 3'h1;
   logic [3:0]            note;
   logic                  pend = 1'b0;
   logic [3:0]            exp_q[$];
   logic [15:0]           seed = 16'h0039;
   int                    err_count = 0;
   int                    samples_checked = 0;
   always #12.5 core_clk = ~core_clk;
   sram_tap_instruction_decode #(.IDENTIFICATION_ROM(ID_VAL)) dut (
      .core_clk(core_clk), .rst(rst), .jtag_in(jtag_in),
      .pad_ring(pad_ring), .tdo(tdo), .tdo_oe(tdo_oe),
      .ram_out_float(ram_out_float), .cur_instr(cur_instr));
   jtag_ctrl ctl (.core_clk(core_clk), .tdo(tdo), .tdo_oe(tdo_oe),
      .jtag_in(jtag_in));
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic rnd64(output logic [63:0] r);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         r[16*i +: 16] = seed;
      end
   endtask
   task automatic expect_op(input logic [2:0] op);
      exp_q.push_back({op == `OP_EXTEST || op == `OP_SAMPLE_Z, op});
   endtask
   // --------
   // capture then shift 64 bits: captured value, then tdi delayed by length
   // --------
   task automatic dr_test(input logic [2:0] op);
      logic [63:0] r;
      logic [63:0] got;
      logic [63:0] cap;
      int          len;
      rnd64(r);
      @(posedge core_clk);
      #1 pad_ring = r[`BSR_WIDTH-1:0];
      rnd64(r);
      case (op)
         `OP_IDCODE: begin
            cap = {32'h0, ID_VAL};
            len = `ID_WIDTH;
         end
         `OP_EXTEST, `OP_SAMPLE_Z, `OP_SAMPLE_PRELOAD: begin
            cap = {13'h0, pad_ring};
            len = `BSR_WIDTH;
         end
         default: begin
            cap = '0;
            len = 1;
         end
      endcase
      ctl.dr_read(r, got);
      check(got, cap | (r << len));
   endtask
   always @(negedge core_clk) begin
      if (pend) begin
         check(ram_out_float, note[3]);
         pend = 1'b0;
      end
      if (cur_instr !== last) begin
         note = (exp_q.size() != 0) ? exp_q.pop_front() : {1'b0, last};
         check(cur_instr, note[2:0]);
         last = cur_instr;
         pend = 1'b1;
      end
   end
   initial begin
      #2000000;
      err_count++;
      tally_and_finish();
   end
   initial begin
      logic [2:0] cap;
      repeat (16) @(posedge core_clk);
      #1 rst = 1'b0;
      repeat (4) @(posedge core_clk);
      check(cur_instr, `OP_IDCODE);
      ctl.walk(8'h00, 1);
      dr_test(`OP_IDCODE);
      for (int i = 0; i < 8; i++) begin
         expect_op(i[2:0]);
         ctl.ir_load(i[2:0], cap);
         check(cap, {`IR_CAPTURE_HIGH, `IR_CAPTURE_LOW});
         dr_test(i[2:0]);
      end
      expect_op(`OP_IDCODE);
      ctl.walk(8'h1f, 5);
      ctl.walk(8'h00, 1);
      expect_op(`OP_RESERVED_6);
      ctl.ir_load(`OP_RESERVED_6, cap);
      expect_op(`OP_IDCODE);
      @(posedge core_clk);
      #1 rst = 1'b1;
      repeat (4) @(posedge core_clk);
      #1 rst = 1'b0;
      repeat (4) @(posedge core_clk);
      ctl.walk(8'h00, 1);
      dr_test(`OP_IDCODE);
      repeat (4) @(posedge core_clk);
      check(exp_q.size(), 0);
      tally_and_finish();
   end
endmodule
